// ==== test/mtc_link_sink.sv ====
// line side partner: collects frames sent by the block
`timescale 1ns/100ps
`default_nettype none
module mtc_link_sink (
    input wire logic        clock_i,  // clock
    input wire logic        nrst_i,   // reset
    input wire logic        valid_i,  // byte valid
    input wire logic        last_i,   // frame end
    input wire logic [7:0]  data_i,   // line byte
    input wire logic [2:0]  csum_i,   // icmp, tcp, ip flags
    output var logic [15:0] len_o,    // length of last frame
    output var logic [15:0] frames_o, // frames seen
    output var logic [2:0]  csum_o,   // flags of last frame
    output var logic        crc_ok_o  // last frame left the good crc residue
);
    localparam logic [31:0] CRC_GOOD = 32'hdebb20e3; // residue of a frame with intact fcs
    logic [15:0] cnt; // bytes of frame in flight
    logic [31:0] crc; // crc register over the frame so far
    logic [31:0] nc;  // crc register with this byte added
    // reflected crc-32 step over the byte on the line, lsb first
    always_comb
    begin
        nc = crc;
        for (int i = 0; i < 8; i++)
            nc = (nc[0] ^ data_i[i]) ? ((nc >> 1) ^ 32'hedb88320) : (nc >> 1);
    end
    // count bytes, record each finished frame
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            cnt <= 16'h0000;
            frames_o <= 16'h0000;
            crc <= 32'hffffffff;
            crc_ok_o <= 1'b0;
        end
        else if (valid_i)
        begin
            cnt <= last_i ? 16'h0000 : cnt + 16'h0001;
            crc <= last_i ? 32'hffffffff : nc;
            if (last_i)
            begin
                crc_ok_o <= (nc == CRC_GOOD);
                len_o <= cnt + 16'h0001;
                csum_o <= csum_i;
                frames_o <= frames_o + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/mtc_monitor.sv ====
// port checker of the transmit control block
`timescale 1ns/100ps
`default_nettype none
module mtc_monitor (
    input wire logic        clock_i,       // clock
    input wire logic        nrst_i,        // reset
    input wire logic        psel_i,        // select
    input wire logic        penable_i,     // enable
    input wire logic        pwrite_i,      // write
    input wire logic [11:0] paddr_i,       // address
    input wire logic [31:0] pwdata_i,      // write data
    input wire logic [31:0] prdata_o,      // read data
    input wire logic        pready_o,      // ready
    input wire logic        pslverr_o,     // error
    input wire logic        tx_valid_o,    // byte valid
    input wire logic        tx_last_o,     // frame end
    input wire logic        csum_icmp_o,   // icmp flag
    input wire logic        full_duplex_i, // duplex
    input wire logic [7:0]  rx_level_i,    // rx level
    input wire logic        pause_req_o,   // pause
    input wire logic        backpressure_o // backpressure
);
    logic [15:0] ctl;  // control shadow
    logic [7:0]  thr;  // threshold shadow
    logic [7:0]  cnt;  // line bytes so far
    logic        wr;   // write completes
    logic        over; // level at threshold
    assign wr = psel_i && penable_i && pready_o && pwrite_i;
    assign over = rx_level_i >= thr;
    // shadow registers and line byte count
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            ctl <= 16'h0000;
            thr <= 8'hc0;
            cnt <= 8'h00;
        end
        else
        begin
            if (wr && paddr_i == 12'h070)
                ctl <= pwdata_i[15:0] & 16'h017f;
            if (wr && paddr_i == 12'h078)
                thr <= pwdata_i[7:0];
            if (tx_valid_o)
                cnt <= tx_last_o ? 8'h00 : cnt + 8'h01;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    a_ready_access: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready in access cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (pready_o && !(paddr_i inside {12'h070, 12'h078, 12'h07c})
        |-> pslverr_o) else $error("unmapped access without error");
    a_control_read: assert property (
        pready_o && !pwrite_i && paddr_i == 12'h070 |-> prdata_o == {16'h0000, ctl})
        else $error("control readback wrong");
    a_pause_rise: assert property (
        ctl[3] && full_duplex_i && over && !$past(over) |-> ##[1:2] pause_req_o)
        else $error("no pause request");
    a_pause_once: assert property (pause_req_o |=> !pause_req_o)
        else $error("pause request too long");
    a_no_flow: assert property (
        !ctl[3] && !$past(ctl[3]) && !$past(ctl[3], 2) |-> !pause_req_o && !backpressure_o)
        else $error("flow control while disabled");
    a_bp_half: assert property ((ctl[3] && !full_duplex_i && over)[*3] |-> backpressure_o)
        else $error("no backpressure");
    a_last_valid: assert property (tx_last_o |-> tx_valid_o)
        else $error("frame end without byte");
    a_icmp_last: assert property (csum_icmp_o |-> tx_last_o && ctl[8])
        else $error("icmp flag out of place");
    a_pad_length: assert property (tx_valid_o && tx_last_o && ctl[2] |-> cnt >= 8'd59)
        else $error("padded frame too short");
endmodule
bind mtc_top mtc_monitor u_mon (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o), .csum_icmp_o(csum_icmp_o),
    .full_duplex_i(full_duplex_i), .rx_level_i(rx_level_i), .pause_req_o(pause_req_o),
    .backpressure_o(backpressure_o));
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench of the transmit control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench;
    logic        clock_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic        in_valid_i, in_last_i, in_ready_o, tx_valid_o, tx_last_o, full_duplex_i;
    logic        csum_ip_o, csum_tcp_o, csum_icmp_o, pause_req_o, backpressure_o, er, fok;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [7:0]  in_data_i, tx_data_o, rx_level_i;
    logic [15:0] flen, frames;
    logic [2:0]  fcs;
    int          fail_count, comparisons, n;
    mtc_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .in_valid_i(in_valid_i),
        .in_data_i(in_data_i), .in_last_i(in_last_i), .in_ready_o(in_ready_o),
        .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
        .csum_ip_o(csum_ip_o), .csum_tcp_o(csum_tcp_o), .csum_icmp_o(csum_icmp_o),
        .full_duplex_i(full_duplex_i), .rx_level_i(rx_level_i), .pause_req_o(pause_req_o),
        .backpressure_o(backpressure_o));
    mtc_link_sink sink (.clock_i(clock_i), .nrst_i(nrst_i), .valid_i(tx_valid_o),
        .last_i(tx_last_o), .data_i(tx_data_o), .csum_i({csum_icmp_o, csum_tcp_o, csum_ip_o}),
        .len_o(flen), .frames_o(frames), .csum_o(fcs), .crc_ok_o(fok));
    task end_sim;
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one apb transfer, then one idle cycle
    task apb(input [11:0] a, input w, input [31:0] d);
        int k;
        begin
            k = 0;
            psel_i <= 1'b1;
            pwrite_i <= w;
            paddr_i <= a;
            pwdata_i <= d;
            @(posedge clock_i);
            penable_i <= 1'b1;
            // hold the request until pready is sampled high at a rising edge
            do
            begin
                @(posedge clock_i);
                k++;
                if (k > 50)
                begin
                    fail_count++;
                    end_sim;
                end
            end while (pready_o !== 1'b1);
            rd = prdata_o;
            er = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
            @(posedge clock_i);
        end
    endtask
    task rchk(input [11:0] a, input [31:0] ex, input ee);
        apb(a, 1'b0, 32'h00000000);
        `CHK("read data", ex, rd);
        `CHK("slave error", ee, er);
    endtask
    // offer frame bytes from..to-1 of a frame of len bytes
    task send(input int from, input int to, input int len, input [7:0] pr, input [7:0] fr);
        int k;
        begin
            for (int i = from; i < to; i++)
            begin
                k = 0;
                in_valid_i <= 1'b1;
                in_last_i <= (i == len - 1);
                in_data_i <= i == 12 ? 8'h08 : i == 13 ? 8'h00 : i == 20 ? fr :
                    i == 21 ? 8'h00 : i == 23 ? pr : 8'(i);
                // the byte is taken at the edge that samples in_ready_o high
                do
                begin
                    @(posedge clock_i);
                    k++;
                    if (k > 500)
                    begin
                        fail_count++;
                        end_sim;
                    end
                end while (in_ready_o !== 1'b1);
            end
            in_valid_i <= 1'b0;
            @(posedge clock_i);
        end
    endtask
    task frame(input [15:0] cnt, input [15:0] ln, input [2:0] cs);
        for (n = 0; n < 400 && frames !== cnt; n++)
            @(posedge clock_i);
        `CHK("frame count", cnt, frames);
        `CHK("frame length", ln, flen);
        `CHK("checksum flags", cs, fcs);
        if (frames !== cnt)
            end_sim;
    endtask
    task pulses(output int c);
        c = 0;
        repeat (6)
        begin
            @(negedge clock_i);
            c = c + (pause_req_o === 1'b1);
        end
        @(posedge clock_i);
    endtask
    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    // main sequence
    initial
    begin
        {nrst_i, psel_i, penable_i, pwrite_i, in_valid_i, in_last_i} = 6'h00;
        {paddr_i, pwdata_i, in_data_i, rx_level_i, full_duplex_i} = 61'h0;
        repeat (20) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        rchk(12'h070, 32'h00000000, 1'b0);
        rchk(12'h078, 32'h000000c0, 1'b0);
        rchk(12'h100, 32'h00000000, 1'b1);
        apb(12'h070, 1'b1, 32'hffffffee);
        rchk(12'h070, 32'h0000016e, 1'b0);
        apb(12'h070, 1'b1, 32'h00000167);
        send(0, 30, 30, 8'h06, 8'h00);
        frame(16'd1, 16'd64, 3'b011);
        `CHK("frame crc", 1'b1, fok);
        send(0, 30, 30, 8'h01, 8'h00);
        frame(16'd2, 16'd64, 3'b101);
        send(0, 30, 30, 8'h01, 8'h20);
        frame(16'd3, 16'd64, 3'b001);
        apb(12'h070, 1'b1, 32'h00000003);
        send(0, 30, 30, 8'h06, 8'h00);
        frame(16'd4, 16'd34, 3'b000);
        apb(12'h070, 1'b1, 32'h00000001);
        send(0, 30, 30, 8'h06, 8'h00);
        frame(16'd5, 16'd30, 3'b000);
        `CHK("frame crc", 1'b0, fok);
        apb(12'h070, 1'b1, 32'h00000003);
        send(0, 20, 70, 8'h06, 8'h00);
        apb(12'h070, 1'b1, 32'h00000002);
        send(20, 70, 70, 8'h06, 8'h00);
        frame(16'd6, 16'd74, 3'b000);
        `CHK("frame crc", 1'b1, fok);
        send(0, 8, 8, 8'h06, 8'h00);
        repeat (40) @(posedge clock_i);
        `CHK("queue ready", 1'b0, in_ready_o);
        apb(12'h07c, 1'b0, 32'h00000000);
        `CHK("queue count", 4'h8, rd[11:8]);
        apb(12'h070, 1'b1, 32'h00000010);
        apb(12'h07c, 1'b0, 32'h00000000);
        `CHK("flushed count", 4'h0, rd[11:8]);
        `CHK("ready in flush", 1'b0, in_ready_o);
        apb(12'h070, 1'b1, 32'h00000000);
        apb(12'h070, 1'b1, 32'h00000003);
        `CHK("ready after flush", 1'b1, in_ready_o);
        send(0, 10, 10, 8'h06, 8'h00);
        frame(16'd7, 16'd14, 3'b000);
        apb(12'h070, 1'b1, 32'h00000008);
        full_duplex_i <= 1'b1;
        rx_level_i <= 8'hd0;
        pulses(n);
        `CHK("pause count", 1, n);
        full_duplex_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        `CHK("backpressure", 1'b1, backpressure_o);
        apb(12'h070, 1'b1, 32'h00000000);
        rx_level_i <= 8'h00;
        repeat (4) @(posedge clock_i);
        `CHK("backpressure off", 1'b0, backpressure_o);
        full_duplex_i <= 1'b1;
        rx_level_i <= 8'hd0;
        pulses(n);
        `CHK("pause while off", 0, n);
        end_sim;
    end
endmodule
`default_nettype wire

// ==== verilog/mtc_regs.vh ====
// register map, field positions and constants of the transmit control block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef MTC_REGS_VH
`define MTC_REGS_VH

// register byte addresses
`define MTC_TXCTL_ADDR   12'h070
`define MTC_THRESH_ADDR  12'h078
`define MTC_STATUS_ADDR  12'h07c

// transmit_control fields
`define MTC_RUN_BIT      0
`define MTC_CRC_BIT      1
`define MTC_PAD_BIT      2
`define MTC_FC_BIT       3
`define MTC_FLUSH_BIT    4
`define MTC_IPCS_BIT     5
`define MTC_TCPCS_BIT    6
`define MTC_ICMPCS_BIT   8
`define MTC_TXCTL_WMASK  16'h017f
`define MTC_TXCTL_RESET  16'h0000
`define MTC_THRESH_RESET 8'hc0

// frame constants
`define MTC_MIN_DATA     11'd60
`define MTC_CRC_INIT     32'hffffffff
`define MTC_CRC_POLY     32'hedb88320
`define MTC_TYPE_IP      16'h0800
`define MTC_PROTO_TCP    8'h06
`define MTC_PROTO_ICMP   8'h01

`endif

// ==== verilog/mtc_top.v ====
// transmit control block: register slave, queue fifo and transmit engine
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "mtc_regs.vh"

//------------------------------------------------------------------------------
// queue fifo
//------------------------------------------------------------------------------
module mtc_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clock_i,  // system clock
    input  wire             nrst_i,   // sync reset, active low
    input  wire             clr_i,    // synchronous clear
    input  wire             in_valid_i, // write request
    input  wire [WIDTH-1:0] in_data_i,  // write data
    output reg              in_ready_o, // room available
    output reg              out_valid_o, // data available
    output wire [WIDTH-1:0] out_data_o,  // head word
    input  wire             out_ready_i, // pop
    output reg  [AW:0]      count_o      // words held
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr;
    reg  [AW-1:0]    rd_ptr;
    wire             push = in_valid_i & in_ready_o & ~clr_i;
    wire             pop  = out_valid_o & out_ready_i & ~clr_i;
    reg  [AW:0]      next_count;

    assign out_data_o = mem[rd_ptr];

    // next fill level
    always @*
    begin
        next_count = count_o;
        if (clr_i)
            next_count = {(AW+1){1'b0}};
        else if (push & ~pop)
            next_count = count_o + 1'b1;
        else if (pop & ~push)
            next_count = count_o - 1'b1;
    end

    // pointers and registered flags
    always @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            wr_ptr      <= {AW{1'b0}};
            rd_ptr      <= {AW{1'b0}};
            count_o     <= {(AW+1){1'b0}};
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end
        else
        begin
            if (clr_i)
            begin
                wr_ptr <= {AW{1'b0}};
                rd_ptr <= {AW{1'b0}};
            end
            else
            begin
                if (push)
                    wr_ptr <= wr_ptr + 1'b1;
                if (pop)
                    rd_ptr <= rd_ptr + 1'b1;
            end
            count_o     <= next_count;
            in_ready_o  <= (next_count != DEPTH[AW:0]) & ~clr_i;
            out_valid_o <= (next_count != {(AW+1){1'b0}});
        end
    end

    // storage
    always @(posedge clock_i)
    begin
        if (push)
            mem[wr_ptr] <= in_data_i;
    end
endmodule

//------------------------------------------------------------------------------
// top: apb registers and transmit engine
//------------------------------------------------------------------------------
module mtc_top (
    input  wire        clock_i,        // 20 MHz clock
    input  wire        nrst_i,         // sync reset, active low
    input  wire        psel_i,         // apb select
    input  wire        penable_i,      // apb enable
    input  wire        pwrite_i,       // apb direction
    input  wire [11:0] paddr_i,        // apb byte address
    input  wire [31:0] pwdata_i,       // apb write data
    output reg  [31:0] prdata_o,       // apb read data
    output reg         pready_o,       // apb ready
    output reg         pslverr_o,      // apb error
    input  wire        in_valid_i,     // frame byte offered
    input  wire [7:0]  in_data_i,      // frame byte
    input  wire        in_last_i,      // last byte of frame
    output wire        in_ready_o,     // queue can take a byte
    output reg         tx_valid_o,     // line byte valid
    output reg  [7:0]  tx_data_o,      // line byte
    output reg         tx_last_o,      // last line byte of frame
    output reg         csum_ip_o,      // ip checksum insert, with tx_last_o
    output reg         csum_tcp_o,     // tcp checksum insert, with tx_last_o
    output reg         csum_icmp_o,    // icmp checksum insert, with tx_last_o
    input  wire        full_duplex_i,  // link is full duplex
    input  wire [7:0]  rx_level_i,     // receive buffer occupancy
    output reg         pause_req_o,    // one-cycle pause frame request
    output reg         backpressure_o  // half duplex backpressure
);
    localparam ST_STOP = 5'h01;
    localparam ST_IDLE = 5'h02;
    localparam ST_DATA = 5'h04;
    localparam ST_PAD  = 5'h08;
    localparam ST_CRC  = 5'h10;

    reg  [15:0] transmit_control;
    reg  [7:0]  pause_threshold;
    reg  [4:0]  state;
    reg  [4:0]  next_state;
    reg  [10:0] byte_cnt;
    reg  [31:0] crc;
    reg  [1:0]  crc_idx;
    reg  [15:0] frame_ctl;
    reg  [15:0] eth_type;
    reg  [13:0] frag;
    reg  [7:0]  proto;
    reg         over_q;
    reg  [31:0] rd_val;
    reg         rd_err;
    wire [3:0]  q_count;
    wire        q_valid;
    wire [8:0]  q_data;
    wire        flush = transmit_control[`MTC_FLUSH_BIT];
    wire        run   = transmit_control[`MTC_RUN_BIT];
    wire        pop   = (state == ST_DATA) & q_valid;
    wire        acc   = psel_i & penable_i & pready_o;
    wire        over  = (rx_level_i >= pause_threshold);
    wire        short = (byte_cnt + 11'd1 < `MTC_MIN_DATA);
    wire [31:0] crc_out = ~crc;

    // one crc-32 step over a byte, lsb first
    function [31:0] crc_byte;
        input [31:0] c;
        input [7:0]  d;
        integer      i;
        reg   [31:0] r;
        begin
            r = c;
            for (i = 0; i < 8; i = i + 1)
                r = (r[0] ^ d[i]) ? ((r >> 1) ^ `MTC_CRC_POLY) : (r >> 1);
            crc_byte = r;
        end
    endfunction

    // the queue between host and line
    mtc_fifo #(
        .WIDTH (9),
        .DEPTH (8),
        .AW    (3)
    ) u_fifo (
        .clock_i     (clock_i),
        .nrst_i      (nrst_i),
        .clr_i       (flush),
        .in_valid_i  (in_valid_i),
        .in_data_i   ({in_last_i, in_data_i}),
        .in_ready_o  (in_ready_o),
        .out_valid_o (q_valid),
        .out_data_o  (q_data),
        .out_ready_i (pop),
        .count_o     (q_count)
    );

    //--------------------------------------------------------------------------
    // register slave
    //--------------------------------------------------------------------------

    // read decode
    always @*
    begin
        rd_val = 32'h00000000;
        rd_err = 1'b0;
        case (paddr_i)
            `MTC_TXCTL_ADDR:  rd_val = {16'h0000, transmit_control};
            `MTC_THRESH_ADDR: rd_val = {24'h000000, pause_threshold};
            `MTC_STATUS_ADDR: rd_val = {20'h00000, q_count, 2'b00,
                                        state == ST_PAD, state == ST_CRC,
                                        state == ST_DATA, state == ST_IDLE,
                                        state == ST_STOP, state != ST_STOP};
            default:          rd_err = 1'b1;
        endcase
    end

    // no wait state: answer prepared in setup, given in the first access cycle
    always @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end
        else
        begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & rd_err;
            prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? rd_val : 32'h00000000;
        end
    end

    // register writes
    always @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            transmit_control <= `MTC_TXCTL_RESET;
            pause_threshold  <= `MTC_THRESH_RESET;
        end
        else if (acc & pwrite_i)
        begin
            if (paddr_i == `MTC_TXCTL_ADDR)
                transmit_control <= pwdata_i[15:0] & `MTC_TXCTL_WMASK;
            if (paddr_i == `MTC_THRESH_ADDR)
                pause_threshold <= pwdata_i[7:0];
        end
    end

    //--------------------------------------------------------------------------
    // transmit engine
    //--------------------------------------------------------------------------

    // state sequencing
    always @*
    begin
        next_state = state;
        case (state)
            ST_STOP: if (run) next_state = ST_IDLE;
            ST_IDLE:
            begin
                if (!run)
                    next_state = ST_STOP;
                else if (q_valid)
                    next_state = ST_DATA;
            end
            ST_DATA:
            begin
                if (q_valid & q_data[8])
                begin
                    if (frame_ctl[`MTC_PAD_BIT] & short)
                        next_state = ST_PAD;
                    else if (frame_ctl[`MTC_CRC_BIT])
                        next_state = ST_CRC;
                    else
                        next_state = ST_IDLE;
                end
            end
            ST_PAD:
            begin
                if (!short)
                    next_state = frame_ctl[`MTC_CRC_BIT] ? ST_CRC : ST_IDLE;
            end
            ST_CRC: if (crc_idx == 2'd3) next_state = ST_IDLE;
            default: next_state = ST_STOP;
        endcase
        if (flush)
            next_state = run ? ST_IDLE : ST_STOP;
    end

    // byte path, crc and header capture
    always @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            state       <= ST_STOP;
            byte_cnt    <= 11'd0;
            crc         <= `MTC_CRC_INIT;
            crc_idx     <= 2'd0;
            frame_ctl   <= 16'h0000;
            eth_type    <= 16'h0000;
            frag        <= 14'h0000;
            proto       <= 8'h00;
            tx_valid_o  <= 1'b0;
            tx_data_o   <= 8'h00;
            tx_last_o   <= 1'b0;
            csum_ip_o   <= 1'b0;
            csum_tcp_o  <= 1'b0;
            csum_icmp_o <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            tx_valid_o <= 1'b0;
            tx_last_o  <= 1'b0;
            csum_ip_o   <= 1'b0;
            csum_tcp_o  <= 1'b0;
            csum_icmp_o <= 1'b0;
            if (flush | (state == ST_IDLE))
            begin
                byte_cnt  <= 11'd0;
                crc       <= `MTC_CRC_INIT;
                crc_idx   <= 2'd0;
                frame_ctl <= transmit_control;
                // header fields start clear so a short frame never reuses old ones
                eth_type  <= 16'h0000;
                frag      <= 14'h0000;
                proto     <= 8'h00;
            end
            else if ((state == ST_DATA) & q_valid)
            begin
                tx_valid_o <= 1'b1;
                tx_data_o  <= q_data[7:0];
                crc        <= crc_byte(crc, q_data[7:0]);
                byte_cnt   <= byte_cnt + 11'd1;
                tx_last_o  <= q_data[8] & ~frame_ctl[`MTC_CRC_BIT]
                              & ~(frame_ctl[`MTC_PAD_BIT] & short);
                if (byte_cnt == 11'd12) eth_type[15:8] <= q_data[7:0];
                if (byte_cnt == 11'd13) eth_type[7:0]  <= q_data[7:0];
                if (byte_cnt == 11'd20) frag[13:8]     <= q_data[5:0];
                if (byte_cnt == 11'd21) frag[7:0]      <= q_data[7:0];
                if (byte_cnt == 11'd23) proto          <= q_data[7:0];
            end
            else if (state == ST_PAD)
            begin
                // zero pad to 60 data bytes
                tx_valid_o <= 1'b1;
                tx_data_o  <= 8'h00;
                crc        <= crc_byte(crc, 8'h00);
                byte_cnt   <= byte_cnt + 11'd1;
                tx_last_o  <= ~short & ~frame_ctl[`MTC_CRC_BIT];
            end
            else if (state == ST_CRC)
            begin
                tx_valid_o <= 1'b1;
                tx_data_o  <= crc_out[8*crc_idx +: 8];
                crc_idx    <= crc_idx + 2'd1;
                tx_last_o  <= (crc_idx == 2'd3);
            end
            // flags only when a frame ends, never when leaving stop
            if ((next_state == ST_IDLE) & (state != ST_IDLE) & (state != ST_STOP) & ~flush)
            begin
                csum_ip_o   <= frame_ctl[`MTC_IPCS_BIT] & (eth_type == `MTC_TYPE_IP);
                csum_tcp_o  <= frame_ctl[`MTC_TCPCS_BIT] & (eth_type == `MTC_TYPE_IP)
                               & (proto == `MTC_PROTO_TCP);
                csum_icmp_o <= frame_ctl[`MTC_ICMPCS_BIT] & (eth_type == `MTC_TYPE_IP)
                               & (proto == `MTC_PROTO_ICMP) & ~frag[13] & (frag[12:0] == 13'h0);
            end
        end
    end

    //--------------------------------------------------------------------------
    // flow control
    //--------------------------------------------------------------------------
    always @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            over_q         <= 1'b0;
            pause_req_o    <= 1'b0;
            backpressure_o <= 1'b0;
        end
        else
        begin
            over_q <= over;
            pause_req_o <= transmit_control[`MTC_FC_BIT] & full_duplex_i & over & ~over_q;
            backpressure_o <= transmit_control[`MTC_FC_BIT] & ~full_duplex_i & over;
        end
    end
endmodule

`default_nettype wire
